/* File: hw/desync_pkg.sv */
/*
 Shared constants for the gapped-clock mapper and the de-synchronizer.
 Assumes a 100 MHz hclk; one 51.84 MHz slot is stood in by two hclk.
*/
package desync_pkg;
   // Burst shapes: slots per burst and clock pulses per burst
   localparam logic [3:0] P1_LEN = 4'h8;
   localparam logic [3:0] P1_PULSES = 4'h7;
   localparam logic [3:0] P2_LEN = 4'h6;
   localparam logic [3:0] P2_PULSES = 4'h5;
   localparam logic [3:0] P3_LEN = 4'h6;
   localparam logic [3:0] P3_PULSES = 4'h6;
   // Burst counts inside each major pattern
   localparam logic [6:0] P1_REPEAT = 7'h3f;
   localparam logic [6:0] A_P2_REPEAT = 7'h24;
   localparam logic [6:0] B_P2_REPEAT = 7'h23;
   // Mapper registers on AHB-Lite
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] SUPER_OFF = 8'h04;
   localparam logic [7:0] PULSE_OFF = 8'h08;
   localparam logic [7:0] POS_OFF = 8'h0c;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'h0;
   localparam logic [6:0] LFSR_SEED = 7'h7f;
   // Device jitter attenuator control registers
   localparam logic [7:0] JA_CH0_OFF = 8'h07;
   localparam logic [7:0] JA_CH1_OFF = 8'h0f;
   localparam logic [7:0] JA_CH2_OFF = 8'h17;
   localparam logic [7:0] ATTENUATOR_FLUSH_VAL = 8'h03;
   localparam logic [7:0] JA_RW_MASK = 8'h1f;
   localparam int unsigned FAST_DIS_BIT = 4;
   localparam int unsigned FLUSH_BIT = 3;
   localparam int unsigned DEPTH_HI_BIT = 2;
   localparam int unsigned ON_TX_BIT = 1;
   localparam int unsigned DEPTH_LO_BIT = 0;
   // Output clock NCO, 16-bit phase per hclk
   localparam logic [15:0] NCO_STEP_NOM = 16'h6e76;
   localparam logic [15:0] NCO_CORR_SLOW = 16'h0010;
   localparam logic [15:0] NCO_CORR_FAST = 16'h0200;
   // Reacquisition window
   localparam int unsigned REACQ_MS = 50;
   localparam int unsigned HCLK_MHZ = 100;
   localparam int unsigned REACQ_CYCLES = REACQ_MS * HCLK_MHZ * 1000;

   typedef enum logic [1:0] {MAJ_A1, MAJ_A2, MAJ_B} major_t;
endpackage : desync_pkg

/* File: hw/link_if.sv */
/*
 Link between mapper and de-synchronizer: gapped clock and data.
 Assumes the mapper drives both; data changes while the clock is low.
*/
`timescale 1ns/1ns
interface link_if;
   logic tx_clock_in;
   logic tx_data;
   modport mapper (output tx_clock_in, output tx_data);
   modport device (input tx_clock_in, input tx_data);
endinterface : link_if

/* File: hw/gap_mapper.sv */
/*
 Mapper end: AHB-Lite slave that produces the gapped super pattern.
 Assumes one AHB-Lite master and this slave alone on the bus.
*/
`timescale 1ns/1ns
module gap_mapper (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   link_if.mapper lk
);
   import desync_pkg::*;

   typedef struct packed {
      logic en;
      logic half;
      desync_pkg::major_t major;
      logic [6:0] burst;
      logic [3:0] pos;
      logic clk;
      logic dat;
      logic [6:0] lfsr;
      logic [15:0] supers;
      logic [31:0] pulses;
      logic wr_pend;
      logic [7:0] waddr;
      logic [31:0] rdata;
      logic ready;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // Slots in the current burst
   function automatic logic [3:0] burst_len(major_t m, logic [6:0] b);
      if (b < P1_REPEAT) begin
         burst_len = P1_LEN;
      end else if (m == MAJ_B && b == P1_REPEAT + B_P2_REPEAT) begin
         burst_len = P3_LEN;
      end else begin
         burst_len = P2_LEN;
      end
   endfunction : burst_len

   // Pulses in the current burst
   function automatic logic [3:0] burst_pulses(major_t m, logic [6:0] b);
      if (b < P1_REPEAT) begin
         burst_pulses = P1_PULSES;
      end else if (m == MAJ_B && b == P1_REPEAT + B_P2_REPEAT) begin
         burst_pulses = P3_PULSES;
      end else begin
         burst_pulses = P2_PULSES;
      end
   endfunction : burst_pulses

   // Last burst of a major pattern
   function automatic logic last_burst(major_t m, logic [6:0] b);
      if (m == MAJ_B) begin
         last_burst = (b == P1_REPEAT + B_P2_REPEAT);
      end else begin
         last_burst = (b == P1_REPEAT + A_P2_REPEAT - 7'h01);
      end
   endfunction : last_burst

   always_comb begin
      logic [3:0] len;
      logic [3:0] npulse;
      len = burst_len(s_r.major, s_r.burst);
      npulse = burst_pulses(s_r.major, s_r.burst);
      s_nxt = s_r;
      s_nxt.ready = 1'b1;

      // Register write data phase
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend && s_r.waddr == CTRL_OFF) begin
         s_nxt.en = hwdata[CTRL_EN_BIT];
      end

      // Address phase
      if (hsel && htrans[1] && hready) begin
         s_nxt.wr_pend = hwrite;
         s_nxt.waddr = haddr[7:0];
         if (!hwrite) begin
            unique case (haddr[7:0])
               CTRL_OFF: begin
                  s_nxt.rdata = {31'h0, s_r.en};
               end
               SUPER_OFF: begin
                  s_nxt.rdata = {16'h0, s_r.supers};
               end
               PULSE_OFF: begin
                  s_nxt.rdata = s_r.pulses;
               end
               POS_OFF: begin
                  s_nxt.rdata = {18'h0, s_r.major, s_r.burst, s_r.pos,
                     s_r.half};
               end
               default: begin
                  s_nxt.rdata = 32'h0;
               end
            endcase
         end
      end

      // Pattern generator, two hclk per slot
      if (!s_r.en) begin
         s_nxt.half = 1'b0;
         s_nxt.clk = 1'b0;
         s_nxt.major = MAJ_A1;
         s_nxt.burst = 7'h00;
         s_nxt.pos = 4'h0;
      end else if (!s_r.half) begin
         s_nxt.half = 1'b1;
         s_nxt.clk = (s_r.pos < npulse);
      end else begin
         s_nxt.half = 1'b0;
         s_nxt.clk = 1'b0;
         if (s_r.clk) begin
            s_nxt.dat = s_r.lfsr[6];
            s_nxt.lfsr = {s_r.lfsr[5:0], s_r.lfsr[6] ^ s_r.lfsr[5]};
            s_nxt.pulses = s_r.pulses + 32'h1;
         end
         if (s_r.pos == len - 4'h1) begin
            s_nxt.pos = 4'h0;
            if (last_burst(s_r.major, s_r.burst)) begin
               s_nxt.burst = 7'h00;
               unique case (s_r.major)
                  MAJ_A1: begin
                     s_nxt.major = MAJ_A2;
                  end
                  MAJ_A2: begin
                     s_nxt.major = MAJ_B;
                  end
                  MAJ_B: begin
                     s_nxt.major = MAJ_A1;
                     s_nxt.supers = s_r.supers + 16'h1;
                  end
                  default: begin
                     s_nxt.major = MAJ_A1;
                  end
               endcase
            end else begin
               s_nxt.burst = s_r.burst + 7'h01;
            end
         end else begin
            s_nxt.pos = s_r.pos + 4'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '{en: CTRL_EN_RESET, half: 1'b0, major: MAJ_A1,
            burst: 7'h00, pos: 4'h0, clk: 1'b0, dat: 1'b0,
            lfsr: LFSR_SEED, supers: 16'h0, pulses: 32'h0,
            wr_pend: 1'b0, waddr: 8'h00, rdata: 32'h0, ready: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.rdata;
   assign hreadyout = s_r.ready;
   assign hresp = 1'b0;
   assign lk.tx_clock_in = s_r.clk;
   assign lk.tx_data = s_r.dat;
endmodule : gap_mapper

/* File: hw/desync_device.sv */
/*
 De-synchronizer end: takes gapped clock and data, smooths to DS3 pulses.
 Assumes the link clock runs only during pulses; core registers on hclk, link side on the gapped clock.
*/
// Contract
// - P1 burst: seven pulses then one gap
// - Major B opens with 63 P1 bursts
// - After 35 P2 bursts, one six-pulse burst
// - Major B: 622 pulses over 720 slots
// - Super pattern: A, A, B, repeat
// - Super pattern: 1864 pulses, 2160 slots
// - Device emits 1864 evenly spaced DS3 pulses
// - Super pattern sent continuously, accepted unbroken
// - Bit 4 zero enables fast recovery (code reads bit 4 of 0x07 only; bit 4 of 0x0f/0x17 has no effect)
// - Fast recovery reframes within 50 ms
// - Hardware mode forces fast recovery on
// - Control registers 0x07/0x0f/0x17, bits 7:5 read-only
// - Major A: 63 P1, 36 P2 bursts
`timescale 1ns/1ns
module desync_device #(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned REACQ = desync_pkg::REACQ_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   link_if.device lk,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic hw_mode,
   output logic ds3_clk_out,
   output logic ds3_data_out
);
   import desync_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 4 || (1 << AW) != DEPTH || REACQ >= (1 << 23)) begin : g_chk
      $error("desync_device: DEPTH must be a power of two, REACQ < 2^23");
   end

   typedef struct packed {
      logic [AW:0] wbin;
      logic [AW:0] wgray;
      logic [DEPTH-1:0] mem;
   } link_st_t;

   typedef struct packed {
      logic [2:0][7:0] ja;
      logic [AW:0] wg1;
      logic [AW:0] wg2;
      logic hw1;
      logic hw2;
      logic [AW:0] rbin;
      logic [15:0] acc;
      logic [22:0] win;
      logic clk;
      logic dat;
      logic [7:0] rdata;
   } core_st_t;

   link_st_t l_r;
   link_st_t l_nxt;
   core_st_t c_r;
   core_st_t c_nxt;

   function automatic logic [AW:0] gray2bin(logic [AW:0] g);
      gray2bin = g;
      for (int i = AW - 1; i >= 0; i--) begin
         gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
   endfunction : gray2bin

   // Link side: every rising gapped clock edge stores one bit
   always_comb begin
      l_nxt = l_r;
      l_nxt.mem[l_r.wbin[AW-1:0]] = lk.tx_data;
      l_nxt.wbin = l_r.wbin + 1'b1;
      l_nxt.wgray = l_nxt.wbin ^ (l_nxt.wbin >> 1);
   end

   always_ff @(posedge lk.tx_clock_in or negedge hresetn) begin
      if (!hresetn) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // Core side: NCO-paced read with fill-steered rate
   always_comb begin
      logic [AW:0] wb;
      logic [AW:0] fill;
      logic fast;
      logic [15:0] corr;
      logic [15:0] step;
      logic [16:0] sum;
      c_nxt = c_r;
      c_nxt.wg1 = l_r.wgray;
      c_nxt.wg2 = c_r.wg1;
      c_nxt.hw1 = hw_mode;
      c_nxt.hw2 = c_r.hw1;
      wb = gray2bin(c_r.wg2);
      fill = wb - c_r.rbin;
      fast = c_r.hw2 || !c_r.ja[0][FAST_DIS_BIT];
      corr = (fast && c_r.win != 23'h0) ? NCO_CORR_FAST : NCO_CORR_SLOW;
      step = NCO_STEP_NOM;
      if (fill > (AW+1)'(DEPTH / 2)) begin
         step = NCO_STEP_NOM + corr;
      end else if (fill < (AW+1)'(DEPTH / 2)) begin
         step = NCO_STEP_NOM - corr;
      end
      sum = {1'b0, c_r.acc} + {1'b0, step};
      c_nxt.acc = sum[15:0];
      c_nxt.clk = 1'b0;
      if (c_r.win != 23'h0) begin
         c_nxt.win = c_r.win - 23'h1;
      end
      if (c_r.ja[0][FLUSH_BIT]) begin
         c_nxt.rbin = wb - (AW+1)'(DEPTH / 2);
         c_nxt.win = 23'(REACQ);
      end else if (sum[16] && fill != '0) begin
         c_nxt.clk = 1'b1;
         c_nxt.dat = l_r.mem[c_r.rbin[AW-1:0]];
         c_nxt.rbin = c_r.rbin + 1'b1;
      end else if (fill == '0) begin
         c_nxt.win = 23'(REACQ);
      end
      if (reg_wr) begin
         unique case (reg_addr)
            JA_CH0_OFF: begin
               c_nxt.ja[0] = reg_wdata & JA_RW_MASK;
            end
            JA_CH1_OFF: begin
               c_nxt.ja[1] = reg_wdata & JA_RW_MASK;
            end
            JA_CH2_OFF: begin
               c_nxt.ja[2] = reg_wdata & JA_RW_MASK;
            end
            default: begin
            end
         endcase
      end
      unique case (reg_addr)
         JA_CH0_OFF: begin
            c_nxt.rdata = c_r.ja[0];
         end
         JA_CH1_OFF: begin
            c_nxt.rdata = c_r.ja[1];
         end
         JA_CH2_OFF: begin
            c_nxt.rdata = c_r.ja[2];
         end
         default: begin
            c_nxt.rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_r <= '{ja: {ATTENUATOR_FLUSH_VAL, ATTENUATOR_FLUSH_VAL, ATTENUATOR_FLUSH_VAL},
            default: '0};
      end else begin
         c_r <= c_nxt;
      end
   end

   assign reg_rdata = c_r.rdata;
   assign ds3_clk_out = c_r.clk;
   assign ds3_data_out = c_r.dat;
endmodule : desync_device

/* File: verif/desync_chk.sv */
/* Checker on the link wire between mapper and de-synchronizer.
   Assumes link signals seen in the hclk domain, hresetn active low. */
`timescale 1ns/1ns
module desync_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tx_clock_in,
   input wire logic tx_data
);
   typedef struct packed {
      logic [2:0] lo;
      logic [3:0] run;
      logic [11:0] sp;
      logic [12:0] hc;
      logic seen;
   } mon_t;
   mon_t s_r;
   mon_t s_nxt;
   logic rise;
   logic wrap;
   assign rise = tx_clock_in & (s_r.lo != 3'h0);
   assign wrap = rise & (s_r.lo == 3'h3) & (s_r.run == 4'hd);
   // Low run length, pulses per burst, pulses and hclk per super pattern
   always_comb begin
      s_nxt = s_r;
      s_nxt.hc = s_r.hc + 13'h1;
      if (tx_clock_in) s_nxt.lo = 3'h0;
      else if (s_r.lo != 3'h7) s_nxt.lo = s_r.lo + 3'h1;
      if (rise) s_nxt.run = (s_r.lo == 3'h1) ? s_r.run + 4'h1 : 4'h1;
      if (rise) s_nxt.sp = s_r.sp + 12'h1;
      if (wrap) begin
         s_nxt.sp = 12'h1;
         s_nxt.hc = 13'h1;
         s_nxt.seen = 1'b1;
      end
      if (s_r.lo == 3'h7) s_nxt.seen = 1'b0;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) s_r <= '{lo: 3'h7, default: '0};
      else s_r <= s_nxt;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence pulse_s;
      tx_clock_in ##1 !tx_clock_in;
   endsequence
   sequence gap_s;
      !tx_clock_in [*2];
   endsequence
   a_slot_shape: assert property (
      $rose(tx_clock_in) |-> pulse_s ##1 (tx_clock_in or gap_s))
      else $error("bad slot shape");
   a_low_runs: assert property (
      rise |-> s_r.lo inside {3'h1, 3'h3, 3'h7})
      else $error("bad low run");
   a_burst_len: assert property (
      rise && s_r.lo == 3'h3 |-> s_r.run inside {4'h5, 4'h7, 4'hd})
      else $error("bad burst length");
   a_run_bound: assert property (s_r.run <= 4'hd)
      else $error("burst too long");
   a_super_pulses: assert property (
      wrap && s_r.seen |-> s_r.sp == 12'h748)
      else $error("bad pulse count");
   a_super_slots: assert property (
      wrap && s_r.seen |-> s_r.hc == 13'h10e0)
      else $error("bad super length");
   a_data_at_rise: assert property (
      $rose(tx_clock_in) |-> $stable(tx_data))
      else $error("data moved at rise");
   a_data_on_fall: assert property (
      $changed(tx_data) |-> $fell(tx_clock_in))
      else $error("data moved off fall");
endmodule : desync_chk

/* File: verif/gapped_clock_desync_input_tb_top.sv */
/* Testbench joining mapper and de-synchronizer over the link.
   Assumes hclk 100 MHz, reset low 4 cycles, REACQ shortened. */
`timescale 1ns/1ns
module gapped_clock_desync_input_tb_top;
   import desync_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [7:0] reg_addr = 8'h0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h0;
   logic [7:0] reg_rdata;
   logic hw_mode = 1'b0;
   logic ds3_clk_out;
   logic ds3_data_out;
   logic meas = 1'b0;
   logic [31:0] rd;
   logic q[$];
   logic [7:0] ja[3] = '{JA_CH0_OFF, JA_CH1_OFF, JA_CH2_OFF};
   int pul[3];
   int err_count = 0;
   int checks = 0;
   int ds3_cnt = 0;
   int last_ds3 = 0;
   int hcnt = 0;
   always #5 hclk = ~hclk;
   link_if lk ();
   gap_mapper gap_mapper_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .lk(lk.mapper));
   desync_device #(.REACQ(200)) desync_device_inst (.hclk(hclk),
      .hresetn(hresetn), .lk(lk.device), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .hw_mode(hw_mode), .ds3_clk_out(ds3_clk_out),
      .ds3_data_out(ds3_data_out));
   desync_chk desync_chk_inst (.hclk(hclk), .hresetn(hresetn),
      .tx_clock_in(lk.tx_clock_in), .tx_data(lk.tx_data));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task bail;
      err_count++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
   endtask : bail
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) bail();
   endtask : wait_rdy
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   task jrd(input logic [7:0] a, input logic [7:0] e);
      @(posedge hclk);
      reg_addr <= a;
      @(posedge hclk);
      @(negedge hclk);
      check({24'h0, reg_rdata}, {24'h0, e});
   endtask : jrd
   task jwr(input logic [7:0] a, input logic [7:0] d);
      @(posedge hclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge hclk);
      reg_wr <= 1'b0;
   endtask : jwr
   function automatic logic exp_slot(int s);
      int t;
      t = s % 720 - 504;
      if (t < 0) return (s % 8) != 7;
      if (s >= 1440 && t >= 210) return 1'b1;
      return (t % 6) != 5;
   endfunction : exp_slot
   // Record link bits, compare them with the DS3 output in order
   always @(negedge hclk) begin
      hcnt++;
      if (lk.tx_clock_in === 1'b1) q.push_back(lk.tx_data);
      if (ds3_clk_out === 1'b1) begin
         ds3_cnt++;
         if (q.size() == 0) check(32'h1, 32'h0);
         else check({31'h0, ds3_data_out}, {31'h0, q.pop_front()});
         if (meas) check({31'h0, (hcnt - last_ds3) inside {2, 3}}, 32'h1);
         last_ds3 = hcnt;
      end
   end
   task super_run(input logic sync);
      int n;
      int c0;
      n = 0;
      pul = '{0, 0, 0};
      if (sync) @(negedge hclk);
      while (sync && lk.tx_clock_in !== 1'b1 && n < 500) begin
         @(negedge hclk);
         n++;
      end
      if (n >= 500) bail();
      c0 = ds3_cnt;
      for (int s = 0; s < 2160; s++) begin
         check({31'h0, lk.tx_clock_in}, {31'h0, exp_slot(s)});
         pul[s / 720] += int'(lk.tx_clock_in === 1'b1);
         @(negedge hclk);
         @(negedge hclk);
      end
      check(pul[0] + pul[1], 32'h4da);
      check(pul[2], 32'h26e);
      check(pul[0] + pul[1] + pul[2], 32'h748);
      if (meas) check({31'h0, (ds3_cnt - c0) inside {[1848:1880]}}, 32'h1);
   endtask : super_run
   task restart;
      meas = 1'b0;
      ahb(1'b1, 32'h0, 32'h0);
      repeat (400) @(posedge hclk);
      ahb(1'b1, 32'h0, 32'h1);
      super_run(1'b1);
      meas = 1'b1;
      super_run(1'b0);
   endtask : restart
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 32'h10, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 3; i++) begin
         jrd(ja[i], 8'h03);
         // Channel 0 flush kept clear: a flush would release stale bits
         jwr(ja[i], (i == 0) ? 8'hf7 : 8'hff);
         jrd(ja[i], (i == 0) ? 8'h17 : 8'h1f);
      end
      jrd(8'h08, 8'h00);
      jwr(JA_CH0_OFF, 8'h03);
      jrd(JA_CH0_OFF, 8'h03);
      $display("test registers done");
      restart();
      $display("test stream done");
      restart();
      $display("test switch recovery done");
      hw_mode <= 1'b1;
      jwr(JA_CH0_OFF, 8'h13);
      restart();
      $display("test hardware mode done");
      complete_run();
   end
endmodule : gapped_clock_desync_input_tb_top
